// [verif/host_model.sv]
`timescale 1ns/10ps
// ****************************************
// host side: mpu bus, serial and i2c master
// ****************************************
module host_model
    import host_if_pkg::*;
(
    input wire logic clk_sys,
    output logic [2:0] mode,
    output logic cs_n,
    output logic a0,
    output logic rd_e,
    output logic wr_rw,
    output logic [7:0] d_in,
    input wire logic [7:0] d_out,
    input wire logic [7:0] d_oe
);
    logic [7:0] pd = 8'h00;
    logic scl = 1'b0;
    logic sda = 1'b1;
    logic e6800;
    // pull-up wire: low if either side pulls; unused pins held low
    assign d_in = mode[2] ? pd
        : {6'h00, sda & ~(d_oe[1] & ~d_out[1]), scl};
    assign e6800 = (mode == MODE_PINS_6800);
    initial set_mode(MODE_PINS_8080, 1'b0);
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask : tick
    task automatic set_mode(input logic [2:0] m, input logic dc);
        mode = m;
        a0 = dc;
        cs_n = 1'b1;
        rd_e = (m != MODE_PINS_6800);
        wr_rw = 1'b1;
    endtask : set_mode
    // strobe only after cs, a0 and data have settled
    task automatic par(input logic rd, input logic dc, input logic [7:0] wd,
        output logic [7:0] rdat);
        cs_n = 1'b0;
        a0 = dc;
        pd = wd;
        wr_rw = e6800 ? rd : 1'b1;
        tick(1);
        if (e6800)
            rd_e = 1'b1;
        else if (rd)
            rd_e = 1'b0;
        else
            wr_rw = 1'b0;
        tick(6);
        rdat = d_out;
        rd_e = ~e6800;
        wr_rw = ~e6800 | rd;
        tick(6);
        cs_n = 1'b1;
        tick(2);
    endtask : par
    // link clock stands still low between frames
    task automatic spi(input int n, input logic [8:0] bits, input logic dc,
        input logic csx);
        cs_n = 1'b0;
        a0 = dc;
        for (int i = n - 1; i >= 0; i--) begin
            sda = bits[i];
            tick(4);
            scl = 1'b1;
            tick(4);
            scl = 1'b0;
        end
        tick(2);
        cs_n = csx;
        tick(4);
    endtask : spi
    task automatic i2c_bit(input logic b, output logic got);
        sda = b;
        tick(4);
        scl = 1'b1;
        tick(2);
        got = d_in[1];
        tick(2);
        scl = 1'b0;
        tick(1);
    endtask : i2c_bit
    task automatic i2c_start;
        sda = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda = 1'b0;
        tick(4);
        scl = 1'b0;
        tick(1);
    endtask : i2c_start
    task automatic i2c_stop;
        sda = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda = 1'b1;
        tick(4);
    endtask : i2c_stop
    task automatic i2c_wr(input logic [7:0] b, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--)
            i2c_bit(b[i], g);
        i2c_bit(1'b1, g);
        ack = ~g;
    endtask : i2c_wr
    task automatic i2c_rd(input logic mack, output logic [7:0] b);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            i2c_bit(1'b1, g);
            b[i] = g;
        end
        i2c_bit(~mack, g);
    endtask : i2c_rd
endmodule : host_model

// [verif/test_display_host_interface.sv]
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
    num_errors++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
// ****************************************
// bench top
// ****************************************
module test_display_host_interface;
    import host_if_pkg::*;
    logic clk_sys, reset = 1'b1, wr_ready = 1'b1, cs_n, a0, rd_e, wr_rw;
    logic ram_rd_next, wr_valid, wr_to_ram, overrun, ack;
    logic [2:0] mode;
    logic [7:0] d_in, d_out, d_oe, wr_byte, r, e;
    logic [7:0] status_in = 8'h5a;
    logic [7:0] ram_rd_data = 8'hc3;
    logic [8:0] got_q[$];
    int num_errors = 0, checked = 0;
    display_host_interface display_host_interface_i (.clk_sys(clk_sys),
        .reset(reset), .interface_mode_pins(mode), .cs_n(cs_n),
        .data_command_select(a0), .strobe_rd_e(rd_e),
        .strobe_wr_rw(wr_rw), .d_in(d_in), .d_out(d_out), .d_oe(d_oe),
        .status_in(status_in), .ram_rd_data(ram_rd_data),
        .ram_rd_next(ram_rd_next), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_byte(wr_byte), .wr_to_ram(wr_to_ram),
        .overrun(overrun));
    host_model host_model_i (.clk_sys(clk_sys), .mode(mode), .cs_n(cs_n),
        .a0(a0), .rd_e(rd_e), .wr_rw(wr_rw), .d_in(d_in), .d_out(d_out),
        .d_oe(d_oe));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // core side: pointer steps on each consumed ram byte
    always @(posedge clk_sys) begin
        if (ram_rd_next === 1'b1)
            ram_rd_data <= ram_rd_data + 8'h01;
        if (wr_valid === 1'b1 && wr_ready === 1'b1)
            got_q.push_back({wr_to_ram, wr_byte});
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    task automatic do_reset(input logic [2:0] m, input logic sa);
        host_model_i.set_mode(m, sa);
        reset = 1'b1;
        host_model_i.tick(10);
        reset = 1'b0;
        host_model_i.tick(6);
        got_q.delete();
    endtask : do_reset
    task automatic pop(input logic [8:0] ex);
        int k;
        logic [8:0] v;
        k = 0;
        while (got_q.size() == 0 && k < 400) begin
            host_model_i.tick(1);
            k++;
        end
        if (got_q.size() == 0) begin
            num_errors++;
            test_done();
        end
        v = got_q.pop_front();
        `CHK("sink", ex, v)
    endtask : pop
    task automatic t_8080;
        do_reset(MODE_PINS_8080, 1'b0);
        host_model_i.par(1'b0, 1'b1, 8'ha5, r);
        host_model_i.par(1'b0, 1'b0, 8'h3c, r);
        pop(9'h1a5);
        pop(9'h03c);
        host_model_i.par(1'b1, 1'b0, 8'h00, r);
        `CHK("status", status_in, r)
        host_model_i.par(1'b1, 1'b1, 8'h00, r);
        e = ram_rd_data - 8'h01;
        host_model_i.par(1'b1, 1'b1, 8'h00, r);
        `CHK("ram read", e, r)
        // far side stalls while the buffer overfills
        wr_ready = 1'b0;
        for (int i = 0; i < 20; i++)
            host_model_i.par(1'b0, 1'b1, 8'(i), r);
        `CHK("overrun", 1'b1, overrun)
        wr_ready = 1'b1;
        host_model_i.tick(40);
        `CHK("held", 1'b1, got_q.size() >= 16)
        pop(9'h100);
        $display("t_8080 done");
    endtask : t_8080
    task automatic t_6800;
        do_reset(MODE_PINS_6800, 1'b0);
        host_model_i.par(1'b0, 1'b1, 8'h81, r);
        pop(9'h181);
        status_in = 8'ha6;
        host_model_i.par(1'b1, 1'b0, 8'h00, r);
        `CHK("status", status_in, r)
        $display("t_6800 done");
    endtask : t_6800
    task automatic t_spi;
        do_reset(3'h0, 1'b0);
        host_model_i.spi(3, 9'h005, 1'b1, 1'b1);
        host_model_i.spi(8, 9'h0b4, 1'b1, 1'b0);
        host_model_i.spi(8, 9'h0e7, 1'b0, 1'b1);
        pop(9'h1b4);
        pop(9'h0e7);
        do_reset(MODE_PINS_SPI3, 1'b0);
        host_model_i.spi(9, 9'h196, 1'b0, 1'b0);
        host_model_i.spi(9, 9'h00f, 1'b0, 1'b1);
        pop(9'h196);
        pop(9'h00f);
        $display("t_spi done");
    endtask : t_spi
    task automatic t_i2c;
        logic [7:0] wb [8] = '{8'h7a, 8'hc0, 8'h11, 8'h9f, 8'he1, 8'h00,
            8'hc0, 8'h33};
        do_reset(MODE_PINS_I2C, 1'b1);
        host_model_i.i2c_start();
        host_model_i.i2c_wr(8'h78, ack);
        `CHK("foreign ack", 1'b0, ack)
        host_model_i.i2c_stop();
        host_model_i.i2c_start();
        for (int i = 0; i < 8; i++) begin
            host_model_i.i2c_wr(wb[i], ack);
            `CHK("ack", 1'b1, ack)
        end
        host_model_i.i2c_stop();
        pop(9'h111);
        pop(9'h0e1);
        pop(9'h0c0);
        pop(9'h033);
        host_model_i.i2c_start();
        host_model_i.i2c_wr(8'h7b, ack);
        `CHK("read ack", 1'b1, ack)
        host_model_i.i2c_rd(1'b1, r);
        `CHK("read 1", status_in, r)
        host_model_i.i2c_rd(1'b0, r);
        `CHK("read 2", status_in, r)
        host_model_i.tick(4);
        `CHK("released", 8'h00, d_oe)
        host_model_i.i2c_stop();
        host_model_i.i2c_start();
        host_model_i.i2c_wr(8'h7a, ack);
        host_model_i.i2c_wr(8'h40, ack);
        `CHK("ctrl ack", 1'b1, ack)
        host_model_i.i2c_stop();
        host_model_i.i2c_start();
        host_model_i.i2c_wr(8'h7b, ack);
        `CHK("ram read ack", 1'b1, ack)
        host_model_i.i2c_rd(1'b1, r);
        e = ram_rd_data - 8'h01;
        host_model_i.i2c_rd(1'b0, r);
        `CHK("ram via i2c", e, r)
        host_model_i.i2c_stop();
        $display("t_i2c done");
    endtask : t_i2c
    initial begin
        #4_000_000;
        num_errors++;
        test_done();
    end
    initial begin
        host_model_i.tick(1);
        t_8080();
        t_6800();
        t_spi();
        t_i2c();
        test_done();
    end
endmodule : test_display_host_interface

// [verilog/display_host_interface.sv]
`timescale 1ns/10ps

// ****************************************
// write buffer
// ****************************************
module byte_fifo #(
    parameter int W = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    // head is kept in a flop so the output never sees the memory mux
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign rp_nxt = pop ? rp_r + AW'(1) : rp_r;
    assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + AW'(1);
            end
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            in_ready <= cnt_nxt != (AW+1)'(DEPTH);
            out_valid <= cnt_nxt != '0;
            out_data <= (push && wp_r == rp_nxt) ? in_data : mem[rp_nxt];
        end
    end
endmodule : byte_fifo

module display_host_interface
    import host_if_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [2:0] interface_mode_pins,
    input wire logic cs_n,
    input wire logic data_command_select,
    input wire logic strobe_rd_e,
    input wire logic strobe_wr_rw,
    input wire logic [7:0] d_in,
    output logic [7:0] d_out,
    output logic [7:0] d_oe,
    input wire logic [7:0] status_in,
    input wire logic [7:0] ram_rd_data,
    output logic ram_rd_next,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [7:0] wr_byte,
    output logic wr_to_ram,
    output logic overrun
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [SYNC_W-1:0] sync1_r, sync2_r, prev_r;
    host_mode_t mode_r;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sync1_r <= SYNC_IDLE;
            sync2_r <= SYNC_IDLE;
            prev_r <= SYNC_IDLE;
        end else begin
            sync1_r <= {interface_mode_pins, cs_n, data_command_select,
                        strobe_rd_e, strobe_wr_rw, d_in};
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    // mode pins are static straps; unknown codes fall back to 4-wire
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mode_r <= mode_spi4;
        end else begin
            case (sync2_r[MODE_LSB +: 3])
                MODE_PINS_6800: mode_r <= mode_6800;
                MODE_PINS_8080: mode_r <= mode_8080;
                MODE_PINS_SPI3: mode_r <= mode_spi3;
                MODE_PINS_I2C: mode_r <= mode_i2c;
                default: mode_r <= mode_spi4;
            endcase
        end
    end

    logic cs_act, a0, scl, sda, scl_rise, scl_fall, i2c_start, i2c_stop;
    logic par_mode, spi_mode, i2c_mode;
    assign cs_act = ~sync2_r[CS_BIT];
    assign a0 = sync2_r[A0_BIT];
    assign scl = sync2_r[D_LSB + SCL_BIT];
    assign sda = sync2_r[D_LSB + SDA_BIT];
    assign scl_rise = scl & ~prev_r[D_LSB + SCL_BIT];
    assign scl_fall = ~scl & prev_r[D_LSB + SCL_BIT];
    assign par_mode = mode_r == mode_6800 || mode_r == mode_8080;
    assign spi_mode = mode_r == mode_spi4 || mode_r == mode_spi3;
    assign i2c_mode = mode_r == mode_i2c;
    assign i2c_start = i2c_mode & scl & prev_r[D_LSB + SCL_BIT]
                       & ~sda & prev_r[D_LSB + SDA_BIT];
    assign i2c_stop = i2c_mode & scl & prev_r[D_LSB + SCL_BIT]
                      & sda & ~prev_r[D_LSB + SDA_BIT];

    // ****************************************
    // parallel bus
    // ****************************************
    logic par_act, par_read, par_end;
    logic par_act_r, par_read_r, par_a0_r, par_drive_r;
    logic [7:0] par_data_r, par_out_r, rd_latch_r;

    always_comb begin
        if (mode_r == mode_6800) begin
            par_act = cs_act & sync2_r[RD_BIT];
            par_read = sync2_r[WR_BIT];
        end else begin
            par_act = cs_act & (~sync2_r[RD_BIT] | ~sync2_r[WR_BIT]);
            par_read = ~sync2_r[RD_BIT];
        end
    end
    assign par_end = par_mode & par_act_r & ~par_act;

    // data and a0 are held from the last active cycle, since the strobe
    // and the bus pass equal synchroniser depth
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            par_act_r <= 1'b0;
            par_read_r <= 1'b0;
            par_a0_r <= 1'b0;
            par_data_r <= BUS_NONE;
            par_drive_r <= 1'b0;
            par_out_r <= BUS_NONE;
        end else begin
            par_act_r <= par_mode & par_act;
            if (par_mode & par_act) begin
                par_read_r <= par_read;
                par_a0_r <= a0;
                par_data_r <= sync2_r[D_LSB +: BYTE_W];
            end
            par_drive_r <= par_mode & par_act & par_read;
            par_out_r <= a0 ? rd_latch_r : status_in;
        end
    end

    // ****************************************
    // 3- and 4-wire serial
    // ****************************************
    logic [3:0] bit_cnt_r, spi_last;
    logic [8:0] shift_r;
    logic spi_done;
    assign spi_last = (mode_r == mode_spi4) ? SPI4_LAST : SPI3_LAST;
    assign spi_done = spi_mode & cs_act & scl_rise & (bit_cnt_r == spi_last);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bit_cnt_r <= CNT_ZERO;
            shift_r <= '0;
        end else if (!spi_mode || !cs_act) begin
            bit_cnt_r <= CNT_ZERO;
        end else if (scl_rise) begin
            shift_r <= {shift_r[7:0], sda};
            bit_cnt_r <= spi_done ? CNT_ZERO : bit_cnt_r + CNT_ONE;
        end
    end

    // ****************************************
    // i2c slave
    // ****************************************
    i2c_state_t state_r;
    i2c_phase_t phase_r;
    logic [3:0] i2c_cnt_r;
    logic [7:0] i2c_sh_r, tx_r, rx_byte, tx_next;
    logic rw_r, dc_last_r, ack_en_r, sda_low_r, byte_in, i2c_load, i2c_push;
    logic fifo_in_ready;

    assign rx_byte = {i2c_sh_r[6:0], sda};
    assign byte_in = state_r == i2c_rx && scl_rise && i2c_cnt_r == I2C_LAST;
    assign tx_next = dc_last_r ? rd_latch_r : status_in;
    assign i2c_load = i2c_mode & scl_fall
                      & ((state_r == i2c_ackhold & rw_r)
                         | state_r == i2c_txack);
    // a full buffer turns into a withheld acknowledge
    assign i2c_push = i2c_mode & byte_in & fifo_in_ready
                      & (phase_r == ph_data | phase_r == ph_stream);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= i2c_idle;
            phase_r <= ph_addr;
            i2c_cnt_r <= CNT_ZERO;
            i2c_sh_r <= BUS_NONE;
            tx_r <= BUS_NONE;
            rw_r <= 1'b0;
            dc_last_r <= 1'b0;
            ack_en_r <= 1'b0;
            sda_low_r <= 1'b0;
        end else if (!i2c_mode || i2c_stop) begin
            state_r <= i2c_idle;
            sda_low_r <= 1'b0;
        end else if (i2c_start) begin
            state_r <= i2c_rx;
            phase_r <= ph_addr;
            i2c_cnt_r <= CNT_ZERO;
            sda_low_r <= 1'b0;
        end else begin
            case (state_r)
                i2c_rx: begin
                    if (scl_rise) begin
                        i2c_sh_r <= rx_byte;
                        i2c_cnt_r <= i2c_cnt_r + CNT_ONE;
                    end
                    if (byte_in) begin
                        state_r <= i2c_ack;
                        ack_en_r <= 1'b1;
                        case (phase_r)
                            ph_addr: begin
                                if (rx_byte[7:1] == {I2C_ADDR_HIGH, a0}) begin
                                    rw_r <= rx_byte[RW_BIT];
                                    phase_r <= ph_ctrl;
                                end else begin
                                    state_r <= i2c_idle;
                                end
                            end
                            ph_ctrl: begin
                                dc_last_r <= rx_byte[DC_BIT];
                                phase_r <= rx_byte[CONT_BIT] ? ph_data
                                                             : ph_stream;
                            end
                            ph_data: begin
                                ack_en_r <= fifo_in_ready;
                                phase_r <= ph_ctrl;
                            end
                            default: begin
                                ack_en_r <= fifo_in_ready;
                            end
                        endcase
                    end
                end
                i2c_ack: begin
                    if (scl_fall) begin
                        sda_low_r <= ack_en_r;
                        state_r <= i2c_ackhold;
                    end
                end
                i2c_ackhold: begin
                    if (scl_fall) begin
                        i2c_cnt_r <= CNT_ZERO;
                        if (rw_r) begin
                            state_r <= i2c_tx;
                            tx_r <= tx_next;
                            sda_low_r <= ~tx_next[7];
                        end else begin
                            state_r <= i2c_rx;
                            sda_low_r <= 1'b0;
                        end
                    end
                end
                i2c_tx: begin
                    if (scl_fall) begin
                        i2c_cnt_r <= i2c_cnt_r + CNT_ONE;
                        tx_r <= {tx_r[6:0], 1'b0};
                        if (i2c_cnt_r == I2C_LAST) begin
                            state_r <= i2c_txack;
                            sda_low_r <= 1'b0;
                        end else begin
                            sda_low_r <= ~tx_r[6];
                        end
                    end
                end
                i2c_txack: begin
                    if (scl_rise && sda) begin
                        state_r <= i2c_idle;
                    end else if (scl_fall) begin
                        state_r <= i2c_tx;
                        i2c_cnt_r <= CNT_ZERO;
                        tx_r <= tx_next;
                        sda_low_r <= ~tx_next[7];
                    end
                end
                default: begin
                    sda_low_r <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // write path into the buffer
    // ****************************************
    logic push_valid_r, overrun_r;
    logic [8:0] push_data_r;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            push_valid_r <= 1'b0;
            push_data_r <= '0;
        end else begin
            push_valid_r <= 1'b0;
            if (par_end && !par_read_r) begin
                push_valid_r <= 1'b1;
                push_data_r <= {par_a0_r, par_data_r};
            end else if (spi_done && mode_r == mode_spi4) begin
                push_valid_r <= 1'b1;
                push_data_r <= {a0, shift_r[6:0], sda};
            end else if (spi_done) begin
                push_valid_r <= 1'b1;
                push_data_r <= {shift_r[7], shift_r[6:0], sda};
            end else if (i2c_push) begin
                push_valid_r <= 1'b1;
                push_data_r <= {dc_last_r, rx_byte};
            end
        end
    end

    // parallel and spi hosts cannot be stalled, so a lost byte is flagged
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            overrun_r <= 1'b0;
        end else if (push_valid_r && !fifo_in_ready) begin
            overrun_r <= 1'b1;
        end
    end

    // ****************************************
    // read pipeline and pin drivers
    // ****************************************
    // ram data is a read behind: each read returns the previous fetch
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rd_latch_r <= BUS_NONE;
            ram_rd_next <= 1'b0;
        end else begin
            ram_rd_next <= 1'b0;
            if ((par_end && par_read_r && par_a0_r)
                || (i2c_load && dc_last_r)) begin
                rd_latch_r <= ram_rd_data;
                ram_rd_next <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            d_out <= BUS_NONE;
            d_oe <= BUS_NONE;
        end else if (i2c_mode) begin
            d_out <= BUS_NONE;
            d_oe <= sda_low_r ? SDA_ONLY : BUS_NONE;
        end else begin
            d_out <= par_out_r;
            d_oe <= par_drive_r ? BUS_ALL : BUS_NONE;
        end
    end

    assign overrun = overrun_r;

    byte_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .reset(reset),
        .in_valid(push_valid_r),
        .in_ready(fifo_in_ready),
        .in_data(push_data_r),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data({wr_to_ram, wr_byte})
    );

    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_par_write: assert property (par_end && !par_read_r |=>
        push_valid_r && push_data_r == {$past(par_a0_r), $past(par_data_r)})
        else $error("parallel write not pushed");
    a_par_read_drive: assert property (
        (par_mode && par_act && par_read) |=> ##1 d_oe == BUS_ALL)
        else $error("parallel read not driven");
    a_spi4_byte: assert property (
        (mode_r == mode_spi4 && spi_done) |=> push_valid_r
        && push_data_r == {$past(a0), $past(shift_r[6:0]), $past(sda)})
        else $error("4-wire byte wrong");
    a_spi3_flag: assert property (
        (mode_r == mode_spi3 && spi_done) |=> push_valid_r
        && push_data_r[8] == $past(shift_r[7]))
        else $error("3-wire flag wrong");
    a_spi_cs_clear: assert property (spi_mode && !cs_act |=>
        bit_cnt_r == CNT_ZERO)
        else $error("counter not cleared");
    a_i2c_ack_low: assert property (
        (state_r == i2c_ack && scl_fall && ack_en_r && !i2c_stop
         && !i2c_start) |=> ##1 d_oe == SDA_ONLY)
        else $error("ack not driven");
    a_addr_ignore: assert property (
        (byte_in && phase_r == ph_addr && !i2c_stop && !i2c_start
         && rx_byte[7:1] != {I2C_ADDR_HIGH, a0}) |=> state_r == i2c_idle)
        else $error("foreign address answered");
    a_nack_release: assert property (
        (state_r == i2c_txack && scl_rise && sda && !i2c_stop) |=>
        state_r == i2c_idle ##1 d_oe == BUS_NONE)
        else $error("read not ended on nack");
    a_start_seen: assert property (i2c_start && !i2c_stop |=>
        state_r == i2c_rx && phase_r == ph_addr && i2c_cnt_r == CNT_ZERO)
        else $error("start missed");
    a_ctrl_stream: assert property (
        (byte_in && phase_r == ph_ctrl && !rx_byte[CONT_BIT]
         && !i2c_stop && !i2c_start) |=> phase_r == ph_stream)
        else $error("stream phase missed");

    c_par_write: cover property (par_end && !par_read_r);
    c_spi3_byte: cover property (mode_r == mode_spi3 && spi_done);
    c_i2c_read: cover property (i2c_load && dc_last_r);
    c_i2c_stream: cover property (i2c_push && phase_r == ph_stream);
endmodule : display_host_interface

// [verilog/host_if_pkg.sv]
package host_if_pkg;

    // ****************************************
    // synchronised pin vector layout
    // ****************************************
    localparam int SYNC_W = 15;
    localparam int D_LSB = 0;
    localparam int WR_BIT = 8;
    localparam int RD_BIT = 9;
    localparam int A0_BIT = 10;
    localparam int CS_BIT = 11;
    localparam int MODE_LSB = 12;
    localparam logic [SYNC_W-1:0] SYNC_IDLE = 15'h0f03;

    // ****************************************
    // mode pins as {im2, im1, im0}
    // ****************************************
    localparam logic [2:0] MODE_PINS_6800 = 3'h4;
    localparam logic [2:0] MODE_PINS_8080 = 3'h6;
    localparam logic [2:0] MODE_PINS_SPI3 = 3'h1;
    localparam logic [2:0] MODE_PINS_I2C = 3'h2;

    // ****************************************
    // serial framing
    // ****************************************
    localparam int SCL_BIT = 0;
    localparam int SDA_BIT = 1;
    localparam int CONT_BIT = 7;
    localparam int DC_BIT = 6;
    localparam int RW_BIT = 0;
    localparam logic [5:0] I2C_ADDR_HIGH = 6'h1e;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
    localparam logic [3:0] SPI4_LAST = 4'h7;
    localparam logic [3:0] SPI3_LAST = 4'h8;
    localparam logic [3:0] I2C_LAST = 4'h7;

    // ****************************************
    // data path
    // ****************************************
    localparam int BYTE_W = 8;
    localparam int FIFO_W = 9;
    localparam int FIFO_DEPTH = 16;
    localparam logic [7:0] BUS_ALL = 8'hff;
    localparam logic [7:0] BUS_NONE = 8'h00;
    localparam logic [7:0] SDA_ONLY = 8'h02;

    typedef enum logic [2:0] {
        mode_6800, mode_8080, mode_spi4, mode_spi3, mode_i2c
    } host_mode_t;

    typedef enum logic [2:0] {
        i2c_idle, i2c_rx, i2c_ack, i2c_ackhold, i2c_tx, i2c_txack
    } i2c_state_t;

    typedef enum logic [1:0] {
        ph_addr, ph_ctrl, ph_data, ph_stream
    } i2c_phase_t;

endpackage : host_if_pkg
